// File: rtl/l2es_top.sv
// APB-controlled event selector and counter for classified L2 cache requests.
`timescale 1ns/100ps
`include "l2es_defines.svh"


module l2es_top #(
    parameter int CNT_W = `L2ES_CNT_W
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`L2ES_ADDR_W-1:0]  paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire l2es_pkg::l2es_req_t      req,
    output logic [CNT_W-1:0]              count_value,
    output logic                          count_overflow
);
    import l2es_pkg::*;

    localparam int HI_W = CNT_W - 32;

    // Merges write data into an old word under the byte strobes.
    function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return res;
    endfunction

    // Registers.
    logic [`L2ES_CTRL_W-1:0] ctrl_ff;
    logic [15:0]             sel_ff;
    logic [CNT_W-1:0]        count_ff;
    logic [HI_W-1:0]         hi_snap_ff;
    logic                    ovf_ff;
    logic [31:0]             req_total_ff;
    logic [31:0]             prdata_ff;
    logic                    clr_ff;

    // Next values.
    logic [`L2ES_CTRL_W-1:0] nxt_ctrl;
    logic [15:0]             nxt_sel;
    logic [CNT_W-1:0]        nxt_count;
    logic [HI_W-1:0]         nxt_hi_snap;
    logic                    nxt_ovf;
    logic [31:0]             nxt_req_total;
    logic [31:0]             nxt_prdata;
    logic                    nxt_clr;

    // Matcher outputs.
    logic                    inc_ff;
    logic                    sel_legal;
    logic [3:0]              state_oh_ff;

    // APB phase decode: setup captures read data, access completes a write.
    wire logic setup_ph   = psel && !penable;
    wire logic access_ph  = psel && penable;
    wire logic wr_access  = access_ph && pwrite;

    // Address decode.
    wire logic hit_ctrl   = (paddr == `L2ES_OFF_CTRL);
    wire logic hit_select = (paddr == `L2ES_OFF_SELECT);
    wire logic hit_cnt_lo = (paddr == `L2ES_OFF_COUNT_LO);
    wire logic hit_cnt_hi = (paddr == `L2ES_OFF_COUNT_HI);
    wire logic hit_status = (paddr == `L2ES_OFF_STATUS);
    wire logic hit_total  = (paddr == `L2ES_OFF_REQ_TOTAL);
    wire logic addr_hit   = hit_ctrl || hit_select || hit_cnt_lo || hit_cnt_hi || hit_status || hit_total;

    // Write strobes per register.
    wire logic wr_ctrl    = wr_access && hit_ctrl;
    wire logic wr_select  = wr_access && hit_select;
    wire logic wr_cnt_lo  = wr_access && hit_cnt_lo;
    wire logic wr_cnt_hi  = wr_access && hit_cnt_hi;
    wire logic wr_status  = wr_access && hit_status;
    wire logic rd_cnt_lo  = setup_ph && !pwrite && hit_cnt_lo;

    // Control fields.
    wire logic cnt_en     = ctrl_ff[`L2ES_CTRL_EN_BIT];
    wire logic frz_on_ovf = ctrl_ff[`L2ES_CTRL_FRZ_BIT];

    // The selection register is viewed as the package type by the matcher.
    wire l2es_sel_t sel_view = l2es_sel_t'(sel_ff);

    // Counter stepping: enabled, and not held by a frozen overflow.
    wire logic cnt_step   = inc_ff && cnt_en && !(frz_on_ovf && ovf_ff);
    wire logic cnt_wrap   = cnt_step && (&count_ff);
    wire logic ovf_clear  = wr_status && pstrb[0] && pwdata[`L2ES_ST_OVF_BIT];

    // Merged words for strobed register writes.
    wire logic [31:0] ctrl_merged = byte_merge({{(32-`L2ES_CTRL_W){1'b0}}, ctrl_ff}, pwdata, pstrb);
    wire logic [31:0] sel_merged  = byte_merge({16'h0000, sel_ff}, pwdata, pstrb);
    wire logic [31:0] lo_merged   = byte_merge(count_ff[31:0], pwdata, pstrb);
    wire logic [31:0] hi_merged   = byte_merge({{(32-HI_W){1'b0}}, count_ff[CNT_W-1:32]}, pwdata, pstrb);

    // Status word seen by software; the one-hot line state is folded back into its two-bit code.
    wire logic [31:0] status_word = {26'h0000000, state_oh_ff[3] | state_oh_ff[2], state_oh_ff[3] | state_oh_ff[1],
                                     1'b0, inc_ff, sel_legal, ovf_ff};

    // Read multiplexer; an unmapped address reads zero.
    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (1'b1)
            hit_ctrl:   rd_word = {{(32-`L2ES_CTRL_W){1'b0}}, ctrl_ff};
            hit_select: rd_word = {16'h0000, sel_ff};
            hit_cnt_lo: rd_word = count_ff[31:0];
            hit_cnt_hi: rd_word = {{(32-HI_W){1'b0}}, hi_snap_ff};
            hit_status: rd_word = status_word;
            hit_total:  rd_word = req_total_ff;
            default:    rd_word = 32'h0000_0000;
        endcase
    end

    // Control register: the clear bit is a command and reads back as zero.
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_clr  = 1'b0;
        if (wr_ctrl) begin
            nxt_ctrl = ctrl_merged[`L2ES_CTRL_W-1:0];
            nxt_ctrl[`L2ES_CTRL_CLR_BIT] = 1'b0;
            nxt_clr  = pstrb[0] && pwdata[`L2ES_CTRL_CLR_BIT];
        end
    end

    // Event selection register.
    assign nxt_sel = wr_select ? sel_merged[15:0] : sel_ff;

    // Counter: clear, then software preset, then a matched request; a write wins over a step in its cycle.
    always_comb begin
        nxt_count = count_ff;
        if (clr_ff) begin
            nxt_count = '0;
        end else if (wr_cnt_lo) begin
            nxt_count[31:0] = lo_merged;
        end else if (wr_cnt_hi) begin
            nxt_count[CNT_W-1:32] = hi_merged[HI_W-1:0];
        end else if (cnt_step) begin
            nxt_count = count_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Overflow flag: a wrap in the cycle of a status clear keeps the flag set; the clear command wins over a wrap.
    always_comb begin
        nxt_ovf = ovf_ff;
        if (ovf_clear || clr_ff) begin
            nxt_ovf = 1'b0;
        end
        if (cnt_wrap && !clr_ff && !wr_cnt_lo && !wr_cnt_hi) begin
            nxt_ovf = 1'b1;
        end
    end

    // Reading the low word freezes the upper bits so that a two-word read is coherent.
    assign nxt_hi_snap   = rd_cnt_lo ? count_ff[CNT_W-1:32] : hi_snap_ff;

    // Every reported request is counted here regardless of the selection.
    assign nxt_req_total = req.valid ? req_total_ff + 32'h0000_0001 : req_total_ff;

    // Read data are captured in the setup phase and held through the access phase.
    assign nxt_prdata    = (setup_ph && !pwrite) ? rd_word : prdata_ff;

    // Classifies each request against the current selection.
    l2es_match u_match (
        .pclk        (pclk),
        .presetn     (presetn),
        .sel         (sel_view),
        .req         (req),
        .inc_ff      (inc_ff),
        .legal       (sel_legal),
        .state_oh_ff (state_oh_ff)
    );

    // Configuration registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `L2ES_CTRL_RST;
            sel_ff  <= `L2ES_SEL_RST;
            clr_ff  <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            sel_ff  <= nxt_sel;
            clr_ff  <= nxt_clr;
        end
    end

    // Counter, overflow and snapshot registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff   <= '0;
            ovf_ff     <= 1'b0;
            hi_snap_ff <= '0;
        end else begin
            count_ff   <= nxt_count;
            ovf_ff     <= nxt_ovf;
            hi_snap_ff <= nxt_hi_snap;
        end
    end

    // Request total and read data registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_total_ff <= 32'h0000_0000;
            prdata_ff    <= 32'h0000_0000;
        end else begin
            req_total_ff <= nxt_req_total;
            prdata_ff    <= nxt_prdata;
        end
    end

    // Bus answers: no wait states, and an error for an unmapped address.
    assign pready         = 1'b1;
    assign pslverr        = access_ph && !addr_hit;
    assign prdata         = prdata_ff;

    // Counter state brought out for the surrounding logic.
    assign count_value    = count_ff;
    assign count_overflow = ovf_ff;

endmodule // l2es_top

// File: rtl/l2es_defines.svh
// Register offsets, field positions, reset values and event selection codes of the L2 request event selector.
`ifndef L2ES_DEFINES_SVH
`define L2ES_DEFINES_SVH

// APB address width and register byte offsets.
`define L2ES_ADDR_W         8
`define L2ES_OFF_CTRL       8'h00
`define L2ES_OFF_SELECT     8'h04
`define L2ES_OFF_COUNT_LO   8'h08
`define L2ES_OFF_COUNT_HI   8'h0C
`define L2ES_OFF_STATUS     8'h10
`define L2ES_OFF_REQ_TOTAL  8'h14

// Control register fields.
`define L2ES_CTRL_EN_BIT    0
`define L2ES_CTRL_CLR_BIT   1
`define L2ES_CTRL_FRZ_BIT   2
`define L2ES_CTRL_W         3
`define L2ES_CTRL_RST       3'h0

// Select register fields: event code in the low byte, unit mask in the next.
`define L2ES_SEL_CODE_LSB   0
`define L2ES_SEL_UMASK_LSB  8
`define L2ES_SEL_RST        16'h0000

// Status register fields.
`define L2ES_ST_OVF_BIT     0
`define L2ES_ST_LEGAL_BIT   1
`define L2ES_ST_HIT_BIT     2
`define L2ES_ST_STATE_LSB   4

// Counter width.
`define L2ES_CNT_W          48

// Event codes.
`define L2ES_EVT_ALL_REQ    8'h24
`define L2ES_EVT_DATA_REQ   8'h26
`define L2ES_EVT_OWNERSHIP  8'h27

// Unit masks: low nibble is demand or store lane, high nibble is prefetch or lock lane.
`define L2ES_UM_LO_I        8'h01
`define L2ES_UM_LO_S        8'h02
`define L2ES_UM_LO_E        8'h04
`define L2ES_UM_LO_M        8'h08
`define L2ES_UM_LO_HIT      8'h0E
`define L2ES_UM_LO_ALL      8'h0F
`define L2ES_UM_HI_I        8'h10
`define L2ES_UM_HI_S        8'h20
`define L2ES_UM_HI_E        8'h40
`define L2ES_UM_HI_M        8'h80
`define L2ES_UM_HI_HIT      8'hE0
`define L2ES_UM_HI_ALL      8'hF0
`define L2ES_UM_ALL         8'hFF

`endif

// File: rtl/l2es_pkg.sv
// Types shared by the L2 request event selector files.
package l2es_pkg;

    // Origin of a classified L2 request; code 7 is unused.
    typedef enum logic [2:0] {
        L2ES_SRC_CODE,
        L2ES_SRC_DEMAND_LOAD,
        L2ES_SRC_L1D_PREFETCH,
        L2ES_SRC_L2_PF_READ,
        L2ES_SRC_L2_PF_RFO,
        L2ES_SRC_STORE_RFO,
        L2ES_SRC_LOCK_RFO
    } l2es_src_t;

    // Coherence state of the target line.
    typedef enum logic [1:0] {
        L2ES_MESI_I,
        L2ES_MESI_S,
        L2ES_MESI_E,
        L2ES_MESI_M
    } l2es_mesi_t;

    // One request reported by the L2 pipeline.
    typedef struct packed {
        logic       valid;
        l2es_src_t  src;
        logic       from_prefetcher;
        l2es_mesi_t state;
    } l2es_req_t;

    // Event selection: unit mask and event code.
    typedef struct packed {
        logic [7:0] umask;
        logic [7:0] code;
    } l2es_sel_t;

endpackage

// File: rtl/l2es_match.sv
// Request classifier that decides whether a reported L2 request matches the selected event.
`timescale 1ns/100ps
`include "l2es_defines.svh"

module l2es_match (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire l2es_pkg::l2es_sel_t sel,
    input  wire l2es_pkg::l2es_req_t req,
    output logic                     inc_ff,
    output logic                     legal,
    output logic [3:0]               state_oh_ff
);
    import l2es_pkg::*;

    // One-hot line state; a prefetch ownership read of a shared line is a miss, a prefetch read stays a hit.
    function automatic logic [3:0] state_bits(input l2es_req_t r);
        logic [3:0] oh;
        oh = 4'h1 << r.state;
        if (r.src == L2ES_SRC_L2_PF_RFO && r.state == L2ES_MESI_S) begin
            oh = 4'h1;
        end
        return oh;
    endfunction

    // Only the listed code and mask pairs count.
    function automatic logic sel_legal(input l2es_sel_t s);
        unique case (s.code)
            `L2ES_EVT_ALL_REQ:   return s.umask == `L2ES_UM_ALL;
            `L2ES_EVT_DATA_REQ:  return s.umask inside {`L2ES_UM_LO_I, `L2ES_UM_LO_S, `L2ES_UM_LO_E, `L2ES_UM_LO_M,
                                                        `L2ES_UM_LO_ALL, `L2ES_UM_HI_I, `L2ES_UM_HI_S, `L2ES_UM_HI_E,
                                                        `L2ES_UM_HI_M, `L2ES_UM_HI_ALL, `L2ES_UM_ALL};
            `L2ES_EVT_OWNERSHIP: return s.umask inside {`L2ES_UM_LO_I, `L2ES_UM_LO_S, `L2ES_UM_LO_M, `L2ES_UM_LO_HIT,
                                                        `L2ES_UM_LO_ALL, `L2ES_UM_HI_I, `L2ES_UM_HI_S, `L2ES_UM_HI_E,
                                                        `L2ES_UM_HI_M, `L2ES_UM_HI_HIT, `L2ES_UM_HI_ALL};
            default:             return 1'b0;
        endcase
    endfunction

    // Places the request's state bit in the lane of the unit mask that its category owns.
    function automatic logic [7:0] req_bits(input logic [7:0] code, input l2es_req_t r);
        logic [3:0] oh;
        oh = state_bits(r);
        unique case (code)
            `L2ES_EVT_ALL_REQ:   return `L2ES_UM_ALL;
            `L2ES_EVT_DATA_REQ: begin
                if (r.src inside {L2ES_SRC_DEMAND_LOAD, L2ES_SRC_L1D_PREFETCH}) return {4'h0, oh};
                if (r.src inside {L2ES_SRC_L2_PF_READ, L2ES_SRC_L2_PF_RFO}) return {oh, 4'h0};
                return 8'h00;
            end
            `L2ES_EVT_OWNERSHIP: begin
                if (r.src == L2ES_SRC_STORE_RFO && !r.from_prefetcher) return {4'h0, oh};
                if (r.src == L2ES_SRC_LOCK_RFO) return {oh, 4'h0};
                return 8'h00;
            end
            default:             return 8'h00;
        endcase
    endfunction

    // Match decision: unions of mask bits follow from the bitwise test.
    wire logic [7:0] hit_bits = req_bits(sel.code, req) & sel.umask;
    wire logic       nxt_inc  = req.valid && legal && (hit_bits != 8'h00);

    assign legal = sel_legal(sel);

    // Registers the increment pulse and the last request's state.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inc_ff      <= 1'b0;
            state_oh_ff <= 4'h0;
        end else begin
            inc_ff      <= nxt_inc;
            state_oh_ff <= req.valid ? state_bits(req) : state_oh_ff;
        end
    end

endmodule // l2es_match

// File: tb/l2es_req_model.sv
// Behavioural model of the L2 request pipeline that reports classified requests.
`timescale 1ns/100ps

module l2es_req_model (
    input  wire logic           pclk,
    output l2es_pkg::l2es_req_t req
);
    import l2es_pkg::*;
    l2es_req_t q[$];

    initial req = '0;

    // Sends one queued request per cycle; between requests the fields toggle so stale values never look valid.
    always @(posedge pclk) begin
        if (q.size() > 0) begin
            req <= q.pop_front();
        end else begin
            req <= {1'b0, ~req[5:0]};
        end
    end

    // Queues one request; requests queued together go out on back-to-back cycles.
    task automatic send(input logic [2:0] src, input logic pf, input logic [1:0] st);
        q.push_back({1'b1, src, pf, st});
    endtask
endmodule // l2es_req_model

// File: tb/l2es_checker.sv
// Concurrent checks of the L2 request event selector counter.
`timescale 1ns/100ps
`include "l2es_defines.svh"

module l2es_checker #(
    parameter int CNT_W = 48
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`L2ES_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    input wire l2es_pkg::l2es_req_t     req,
    input wire logic [CNT_W-1:0]        count_value,
    input wire logic                    count_overflow
);
    import l2es_pkg::*;
    logic [2:0]       busy_ff;
    logic [2:0]       ctrl_ff;
    logic [15:0]      sel_ff;
    l2es_req_t        req1_ff;
    l2es_req_t        req2_ff;
    logic [CNT_W-1:0] sum_ff;
    wire              apb_wr = psel && penable && pwrite;
    wire              quiet  = (busy_ff == 3'h0);
    wire              armed  = quiet && ctrl_ff[0] && !ctrl_ff[2] && req2_ff.valid;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Tracks recent bus use, the selection software wrote and the request two cycles back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 3'h7;
            ctrl_ff <= 3'h0;
            sel_ff  <= 16'h0000;
            req1_ff <= '0;
            req2_ff <= '0;
            sum_ff  <= '0;
        end else begin
            busy_ff <= {busy_ff[1:0], psel};
            if (apb_wr && paddr == `L2ES_OFF_CTRL) ctrl_ff <= pwdata[2:0];
            if (apb_wr && paddr == `L2ES_OFF_SELECT) sel_ff <= pwdata[15:0];
            req1_ff <= req;
            req2_ff <= req1_ff;
            sum_ff  <= count_value + 1'b1;
        end
    end

    property p_all_step; armed && sel_ff == 16'hFF24 |-> count_value == sum_ff; endproperty
    a_all_step: assert property (p_all_step) else $error("all-request step missed");
    property p_l1_pf;
        armed && sel_ff == 16'h0126 && req2_ff.src == L2ES_SRC_L1D_PREFETCH && req2_ff.state == L2ES_MESI_I
        |-> count_value == sum_ff;
    endproperty
    a_l1_pf: assert property (p_l1_pf) else $error("first-level prefetch not a demand load");
    property p_rfo_s;
        armed && sel_ff == 16'h1026 && req2_ff.src == L2ES_SRC_L2_PF_RFO && req2_ff.state == L2ES_MESI_S
        |-> count_value == sum_ff;
    endproperty
    a_rfo_s: assert property (p_rfo_s) else $error("prefetch ownership of shared line not a miss");
    property p_store_pf; armed && sel_ff == 16'h0F27 && req2_ff.from_prefetcher |-> $stable(count_value); endproperty
    a_store_pf: assert property (p_store_pf) else $error("prefetcher store ownership counted");
    property p_unlisted; quiet && !(sel_ff[7:0] inside {8'h24, 8'h26, 8'h27}) |-> $stable(count_value); endproperty
    a_unlisted: assert property (p_unlisted) else $error("unlisted code counted");
    property p_off; quiet && !ctrl_ff[0] |-> $stable(count_value); endproperty
    a_off: assert property (p_off) else $error("disabled counter moved");
    property p_idle; quiet && !req2_ff.valid |-> $stable(count_value); endproperty
    a_idle: assert property (p_idle) else $error("count without request");
    property p_one; quiet |-> count_value == sum_ff || $stable(count_value); endproperty
    a_one: assert property (p_one) else $error("counter stepped by more than one");
    property p_wrap; $rose(count_overflow) |-> count_value == '0; endproperty
    a_wrap: assert property (p_wrap) else $error("overflow without wrap");
    property p_sticky; quiet && $past(count_overflow) |-> count_overflow; endproperty
    a_sticky: assert property (p_sticky) else $error("overflow dropped");

    c_wrap: cover property ($rose(count_overflow));
    c_b2b: cover property (req.valid [*3]);
    c_err: cover property (pslverr);
endmodule // l2es_checker

bind l2es_top l2es_checker #(.CNT_W(CNT_W)) i_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req(req), .count_value(count_value), .count_overflow(count_overflow));

// File: tb/test_l2_request_event_selector.sv
// Self-checking testbench of the L2 request event selector.
`timescale 1ns/100ps
`include "l2es_defines.svh"

module test_l2_request_event_selector;
    import l2es_pkg::*;
    localparam int CW = 40;
    logic          pclk = 1'b0;
    logic          presetn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [3:0]    pstrb = 4'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    l2es_req_t     req;
    logic [CW-1:0] count_value;
    logic          count_overflow;
    logic [31:0]   rd;
    logic          rerr;
    logic [31:0]   sent = 32'h0;
    int            err_count = 0;
    int            comparisons = 0;

    always #2 pclk = ~pclk;

    l2es_top #(.CNT_W(CW)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .req(req), .count_value(count_value), .count_overflow(count_overflow));
    l2es_req_model i_src (.pclk(pclk), .req(req));

    // Prints the counts and the verdict, then stops.
    task automatic complete_run;
        $display("counts: %0d mismatches in %0d comparisons", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
            err_count++;
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= wr ? 4'hF : 4'h0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            $display("mismatch pready expected 1 seen 0");
            err_count++;
            complete_run();
        end
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Clears and enables the counter, selects an event, sends one request and checks the count.
    task automatic ev(input logic [7:0] code, input logic [7:0] um, input logic [2:0] src, input logic pf,
                      input logic [1:0] st, input logic exp);
        apb(1'b1, `L2ES_OFF_CTRL, 32'h3);
        apb(1'b1, `L2ES_OFF_SELECT, {16'h0, um, code});
        repeat (2) @(posedge pclk);
        i_src.send(src, pf, st);
        sent++;
        repeat (5) @(posedge pclk);
        #1;
        check($sformatf("count %h/%h src %0d", code, um, src), {63'h0, exp}, count_value);
    endtask

    task automatic t_regs;
        apb(1'b0, `L2ES_OFF_SELECT, 32'h0);
        check("select reset", 32'h0, rd);
        apb(1'b1, `L2ES_OFF_REQ_TOTAL, 32'hFFFF);
        apb(1'b0, `L2ES_OFF_REQ_TOTAL, 32'h0);
        check("request total", 32'h0, rd);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 1'b1, rerr);
        check("unmapped data", 32'h0, rd);
        $display("test regs done");
    endtask

    task automatic t_demand;
        ev(8'h24, 8'hFF, 3'h0, 1'b0, 2'h1, 1'b1);
        ev(8'h26, 8'h01, 3'h1, 1'b0, 2'h0, 1'b1);
        ev(8'h26, 8'h02, 3'h1, 1'b0, 2'h1, 1'b1);
        ev(8'h26, 8'h04, 3'h1, 1'b0, 2'h2, 1'b1);
        ev(8'h26, 8'h08, 3'h1, 1'b0, 2'h3, 1'b1);
        ev(8'h26, 8'h02, 3'h1, 1'b0, 2'h3, 1'b0);
        ev(8'h26, 8'h01, 3'h2, 1'b0, 2'h0, 1'b1);
        ev(8'h26, 8'h0F, 3'h2, 1'b0, 2'h3, 1'b1);
        ev(8'h26, 8'h0F, 3'h3, 1'b0, 2'h0, 1'b0);
        ev(8'h26, 8'hFF, 3'h1, 1'b0, 2'h2, 1'b1);
        ev(8'h26, 8'hFF, 3'h4, 1'b0, 2'h0, 1'b1);
        ev(8'h26, 8'hFF, 3'h5, 1'b0, 2'h0, 1'b0);
        $display("test demand done");
    endtask

    task automatic t_prefetch;
        ev(8'h26, 8'h10, 3'h3, 1'b0, 2'h0, 1'b1);
        ev(8'h26, 8'h20, 3'h3, 1'b0, 2'h1, 1'b1);
        ev(8'h26, 8'h40, 3'h3, 1'b0, 2'h2, 1'b1);
        ev(8'h26, 8'h80, 3'h4, 1'b0, 2'h3, 1'b1);
        ev(8'h26, 8'h10, 3'h4, 1'b0, 2'h1, 1'b1);
        ev(8'h26, 8'h20, 3'h4, 1'b0, 2'h1, 1'b0);
        ev(8'h26, 8'hF0, 3'h3, 1'b0, 2'h3, 1'b1);
        ev(8'h26, 8'hF0, 3'h2, 1'b0, 2'h0, 1'b0);
        $display("test prefetch done");
    endtask

    task automatic t_ownership;
        ev(8'h27, 8'h01, 3'h5, 1'b0, 2'h0, 1'b1);
        ev(8'h27, 8'h02, 3'h5, 1'b0, 2'h1, 1'b1);
        ev(8'h27, 8'h08, 3'h5, 1'b0, 2'h3, 1'b1);
        ev(8'h27, 8'h0E, 3'h5, 1'b0, 2'h2, 1'b1);
        ev(8'h27, 8'h0E, 3'h5, 1'b0, 2'h0, 1'b0);
        ev(8'h27, 8'h0F, 3'h5, 1'b0, 2'h1, 1'b1);
        ev(8'h27, 8'h0F, 3'h5, 1'b1, 2'h3, 1'b0);
        ev(8'h27, 8'h10, 3'h6, 1'b0, 2'h0, 1'b1);
        ev(8'h27, 8'h20, 3'h6, 1'b0, 2'h1, 1'b1);
        ev(8'h27, 8'h40, 3'h6, 1'b0, 2'h2, 1'b1);
        ev(8'h27, 8'h80, 3'h6, 1'b0, 2'h3, 1'b1);
        ev(8'h27, 8'hE0, 3'h6, 1'b0, 2'h1, 1'b1);
        ev(8'h27, 8'hE0, 3'h6, 1'b0, 2'h0, 1'b0);
        ev(8'h27, 8'hF0, 3'h6, 1'b0, 2'h2, 1'b1);
        ev(8'h27, 8'hF0, 3'h5, 1'b0, 2'h2, 1'b0);
        ev(8'h27, 8'h04, 3'h5, 1'b0, 2'h2, 1'b0);
        ev(8'h28, 8'h01, 3'h1, 1'b0, 2'h0, 1'b0);
        ev(8'h24, 8'h01, 3'h1, 1'b0, 2'h0, 1'b0);
        $display("test ownership done");
    endtask

    // Back-to-back requests wrap a preset counter, then the flag is cleared and counting disabled.
    task automatic t_wrap;
        apb(1'b1, `L2ES_OFF_CTRL, 32'h3);
        apb(1'b1, `L2ES_OFF_SELECT, 32'hFF24);
        apb(1'b1, `L2ES_OFF_COUNT_HI, 32'hFF);
        apb(1'b1, `L2ES_OFF_COUNT_LO, 32'hFFFFFFFE);
        repeat (2) @(posedge pclk);
        i_src.send(3'h1, 1'b0, 2'h0);
        i_src.send(3'h0, 1'b0, 2'h1);
        i_src.send(3'h6, 1'b0, 2'h3);
        sent += 3;
        repeat (7) @(posedge pclk);
        #1;
        check("wrapped count", 40'h1, count_value);
        check("overflow", 1'b1, count_overflow);
        apb(1'b0, `L2ES_OFF_COUNT_LO, 32'h0);
        check("count low word", 32'h1, rd);
        apb(1'b0, `L2ES_OFF_COUNT_HI, 32'h0);
        check("count high word", 32'h0, rd);
        apb(1'b0, `L2ES_OFF_STATUS, 32'h0);
        check("status word", 32'h33, rd);
        apb(1'b1, `L2ES_OFF_CTRL, 32'h5);
        i_src.send(3'h1, 1'b0, 2'h0);
        sent++;
        repeat (5) @(posedge pclk);
        #1;
        check("frozen count", 40'h1, count_value);
        apb(1'b1, `L2ES_OFF_STATUS, 32'h1);
        apb(1'b1, `L2ES_OFF_CTRL, 32'h0);
        i_src.send(3'h1, 1'b0, 2'h0);
        sent++;
        repeat (5) @(posedge pclk);
        #1;
        check("overflow cleared", 1'b0, count_overflow);
        check("disabled count", 40'h1, count_value);
        apb(1'b0, `L2ES_OFF_REQ_TOTAL, 32'h0);
        check("request total", sent, rd);
        $display("test wrap done");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_demand();
        t_prefetch();
        t_ownership();
        t_wrap();
        complete_run();
    end
endmodule // test_l2_request_event_selector
